// file: rscp_pkg.sv
package rscp_pkg;
  // Command byte patterns
  localparam logic [1:0] OP_REG_WR = 2'h1;
  localparam logic [1:0] OP_REG_RD = 2'h3;
  localparam logic [2:0] PFX_BANK = 3'h1;
  localparam logic [2:0] PFX_STREAM = 3'h1;
  localparam logic [7:0] CMD_SOFT_RST = 8'h08;
  localparam logic [7:0] CMD_TXPTR_RST = 8'h09;
  localparam logic [7:0] CMD_RXPTR_RST = 8'h89;
  localparam logic [7:0] CMD_DEEP = 8'h0A;
  localparam logic [7:0] CMD_IDLE = 8'h0B;
  localparam logic [7:0] CMD_LIGHT = 8'h0C;
  localparam logic [7:0] CMD_STANDBY = 8'h0D;
  localparam logic [7:0] CMD_TX = 8'h0E;
  localparam logic [7:0] CMD_RX = 8'h8E;
  localparam logic [7:0] CMD_CHIP_ID = 8'h9F;
  // Field positions and reset values
  localparam int ADDR_W = 6;
  localparam int BANK_W = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    MODE_PWR_DOWN = 3'b000,
    MODE_DEEP = 3'b001,
    MODE_LIGHT = 3'b010,
    MODE_IDLE = 3'b011,
    MODE_STANDBY = 3'b100,
    MODE_TX = 3'b101,
    MODE_RX = 3'b110
  } rscp_mode_e;

  typedef enum logic [3:0] {
    ST_CMD = 4'b0000,
    ST_REG_WR = 4'b0001,
    ST_REG_RD = 4'b0010,
    ST_SYNC_WR = 4'b0011,
    ST_SYNC_RD = 4'b0100,
    ST_FIFO_WR = 4'b0101,
    ST_FIFO_RD = 4'b0110,
    ST_ID_RD = 4'b0111,
    ST_IGNORE = 4'b1000
  } rscp_state_e;
endpackage : rscp_pkg

// file: rscp_sync2.sv
`timescale 1ns/10ps
module rscp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : rscp_sync2

// file: rscp_regfile.sv
`timescale 1ns/10ps
module rscp_regfile #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic clear,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] mem_d [2**AW];

  // Flops rather than RAM so a clear can restore every byte at once
  always_comb begin
    mem_d = mem_q;
    if (clear) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_d[i] = '0;
      end
    end else if (we) begin
      mem_d[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    rdata_q <= mem_q[raddr];
  end
endmodule : rscp_regfile

// file: rscp_command_port.sv
`timescale 1ns/10ps
// Behaviour
// RQ1 - three-wire or four-wire link, up to 4Mbps
// RQ2 - command byte then whole data bytes
// RQ3 - burst address wraps to zero
// RQ4 - chip select low frames every access
// RQ5 - input bits captured on rising clock
// RQ6 - read bits shifted out on falling clock
// RQ7 - bytes travel most significant bit first
// RQ8 - 01 prefix writes registers at address
// RQ9 - 11 prefix reads registers at address
// RQ10 - 001 prefix selects register bank
// RQ11 - 001 in bits six-four: sync/FIFO
// RQ12 - 9F returns chip identity, beats FIFO
// RQ13 - soft reset, TX/RX pointer resets
// RQ14 - commands are command-only or with-data
// RQ15 - address increments after each byte
// RQ16 - bursts allowed while chip select held
// RQ17 - sleep holds general I/O levels
// RQ18 - seven operating modes
// RQ19 - strobe commands change operating mode
// RQ20 - mode sets registers and block enables
// RQ21 - software computes divider and IF fields
// RQ22 - crystal clock drives the system-side logic; link-side counter and shift registers run on the serial clock
// RQ23 - unknown commands change nothing
// RQ24 - power down leads to deep sleep
module rscp_command_port import rscp_pkg::*; #(
  parameter int SYNC_BYTES = 4,
  // Arbitrary identity value
  parameter logic [8*SYNC_BYTES-1:0] CHIP_ID = 32'h5A5A_0001,
  parameter int FIFO_AW = 6
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic four_wire_en,
  input wire logic out_on_gio_two,
  input wire logic gio_one_level,
  input wire logic gio_one_drive,
  input wire logic gio_two_level,
  input wire logic gio_two_drive,
  output logic general_io_one_out,
  output logic general_io_one_oe,
  output logic general_io_two_out,
  output logic general_io_two_oe,
  output logic tx_fifo_we,
  output logic [7:0] tx_fifo_wdata,
  output logic [FIFO_AW-1:0] tx_fifo_ptr,
  output logic rx_fifo_re,
  output logic [FIFO_AW-1:0] rx_fifo_ptr,
  input wire logic [7:0] rx_fifo_rdata,
  output logic [8*SYNC_BYTES-1:0] frame_sync_pattern,
  output rscp_mode_e op_mode,
  output logic low_freq_rc_osc_en,
  output logic regulator_en,
  output logic xtal_en,
  output logic synth_en,
  output logic tx_en,
  output logic rx_en
);
  localparam int IW = $clog2(SYNC_BYTES);

  // Link side, on the serial clock
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic cmd_phase_q, cmd_phase_d;
  logic [6:0] shift_in_q, shift_in_d;
  logic [7:0] rx_word_q, rx_word_d;
  logic rx_cmd_q, rx_cmd_d;
  logic rx_tog_q, rx_tog_d;
  logic [7:0] out_shift_q, out_shift_d;
  logic out_oe_q, out_oe_d;
  logic load_out;
  // System side
  logic cs_high, tog_sync, tog_seen_q, evt, cmd_evt;
  rscp_state_e st_q, st_d;
  rscp_mode_e mode_q, mode_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [IW-1:0] idx_q, idx_d;
  logic [FIFO_AW-1:0] txp_q, txp_d, rxp_q, rxp_d;
  logic [SYNC_BYTES-1:0][7:0] sync_q, sync_d;
  logic fetch_q, fetch_d, fetch2_q;
  logic [7:0] tx_word_q, tx_word_d;
  logic rd_active_q, rd_active_d;
  logic soft_rst, reg_we, txw_d, rxr_d, txw_q, rxr_q;
  logic [7:0] reg_rdata;
  logic [5:0] en_q, en_d;
  logic [3:0] gio_q, gio_d;
  logic sleeping;

  // RQ4 link counter cleared
  always_comb begin
    bit_cnt_d = bit_cnt_q + 3'h1;
    cmd_phase_d = cmd_phase_q && (bit_cnt_q != BIT_LAST);
  end

  always_ff @(posedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_q <= BIT_FIRST;
      cmd_phase_q <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      cmd_phase_q <= cmd_phase_d;
    end
  end

  // RQ5 rising edge capture
  always_comb begin
    shift_in_d = shift_in_q;
    rx_word_d = rx_word_q;
    rx_cmd_d = rx_cmd_q;
    rx_tog_d = rx_tog_q;
    if (!chip_select_n) begin
      shift_in_d = {shift_in_q[5:0], serial_data_in};
      // RQ2 whole bytes only
      if (bit_cnt_q == BIT_LAST) begin
        rx_word_d = {shift_in_q, serial_data_in};
        rx_cmd_d = cmd_phase_q;
        rx_tog_d = ~rx_tog_q;
      end
    end
  end

  always_ff @(posedge serial_clk or posedge reset) begin
    if (reset) begin
      shift_in_q <= 7'h00;
      rx_word_q <= BYTE_RST;
      rx_cmd_q <= 1'b0;
      rx_tog_q <= 1'b0;
    end else begin
      shift_in_q <= shift_in_d;
      rx_word_q <= rx_word_d;
      rx_cmd_q <= rx_cmd_d;
      rx_tog_q <= rx_tog_d;
    end
  end

  // RQ6 falling edge shift
  // tx_word_q settles several system cycles before this edge reads it
  always_comb begin
    load_out = (bit_cnt_q == BIT_FIRST) && !cmd_phase_q;
    out_shift_d = load_out ? tx_word_q : {out_shift_q[6:0], 1'b0};
    out_oe_d = load_out ? rd_active_q : out_oe_q;
  end

  always_ff @(negedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_shift_q <= BYTE_RST;
      out_oe_q <= 1'b0;
    end else begin
      out_shift_q <= out_shift_d;
      out_oe_q <= out_oe_d;
    end
  end

  // RQ1 pin routing
  // RQ7 MSB leaves first
  always_comb begin
    serial_data_out = out_shift_q[7];
    serial_data_oe = out_oe_q && !four_wire_en;
    general_io_one_out = gio_q[0];
    general_io_one_oe = gio_q[1];
    general_io_two_out = gio_q[2];
    general_io_two_oe = gio_q[3];
    if (four_wire_en && !out_on_gio_two) begin
      general_io_one_out = out_shift_q[7];
      general_io_one_oe = out_oe_q;
    end
    if (four_wire_en && out_on_gio_two) begin
      general_io_two_out = out_shift_q[7];
      general_io_two_oe = out_oe_q;
    end
  end

  // RQ22 crystal clock domain
  rscp_sync2 #(.W(2), .RST_VAL(2'b01)) u_sync (
    .clk(sys_clk),
    .rst(reset),
    .d({rx_tog_q, chip_select_n}),
    .q({tog_sync, cs_high})
  );

  assign evt = tog_sync ^ tog_seen_q;
  assign cmd_evt = evt && rx_cmd_q;

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    addr_d = addr_q;
    bank_d = bank_q;
    idx_d = idx_q;
    txp_d = txp_q;
    rxp_d = rxp_q;
    sync_d = sync_q;
    fetch_d = 1'b0;
    soft_rst = 1'b0;
    reg_we = 1'b0;
    txw_d = 1'b0;
    rxr_d = 1'b0;
    // RQ24 leave power down
    if (mode_q == MODE_PWR_DOWN) mode_d = MODE_DEEP;
    if (cmd_evt) begin
      fetch_d = 1'b1;
      idx_d = '0;
      addr_d = rx_word_q[ADDR_W-1:0];
      // RQ14 command-only default
      st_d = ST_IGNORE;
      // RQ8 register write
      if (rx_word_q[7:6] == OP_REG_WR) st_d = ST_REG_WR;
      // RQ9 register read
      else if (rx_word_q[7:6] == OP_REG_RD) st_d = ST_REG_RD;
      // RQ12 identity first
      else if (rx_word_q == CMD_CHIP_ID) st_d = ST_ID_RD;
      // RQ11 sync or FIFO
      else if (rx_word_q[6:4] == PFX_STREAM) begin
        if (rx_word_q[0]) st_d = rx_word_q[7] ? ST_FIFO_RD : ST_FIFO_WR;
        else st_d = rx_word_q[7] ? ST_SYNC_RD : ST_SYNC_WR;
      end
      // RQ10 bank select
      else if (rx_word_q[7:5] == PFX_BANK) bank_d = rx_word_q[1:0];
      else begin
        // RQ13 resets
        // RQ19 mode strobes
        // RQ23 others ignored
        case (rx_word_q)
          CMD_SOFT_RST: soft_rst = 1'b1;
          CMD_TXPTR_RST: txp_d = '0;
          CMD_RXPTR_RST: rxp_d = '0;
          CMD_DEEP: mode_d = MODE_DEEP;
          CMD_IDLE: mode_d = MODE_IDLE;
          CMD_LIGHT: mode_d = MODE_LIGHT;
          CMD_STANDBY: mode_d = MODE_STANDBY;
          CMD_TX: mode_d = MODE_TX;
          CMD_RX: mode_d = MODE_RX;
          default: ;
        endcase
      end
    end else if (evt) begin
      // RQ16 burst bytes
      fetch_d = 1'b1;
      unique case (st_q)
        // RQ15 address steps
        // RQ3 wraps at top
        ST_REG_WR: begin
          reg_we = 1'b1;
          addr_d = addr_q + 6'h01;
        end
        ST_REG_RD: addr_d = addr_q + 6'h01;
        ST_SYNC_WR: begin
          sync_d[idx_q] = rx_word_q;
          idx_d = idx_q + 1'b1;
        end
        ST_SYNC_RD, ST_ID_RD: idx_d = idx_q + 1'b1;
        ST_FIFO_WR: begin
          txw_d = 1'b1;
          txp_d = txp_q + 1'b1;
        end
        ST_FIFO_RD: begin
          rxr_d = 1'b1;
          rxp_d = rxp_q + 1'b1;
        end
        ST_CMD, ST_IGNORE: ;
      endcase
    end
    if (cs_high && !evt) st_d = ST_CMD;
    if (soft_rst) begin
      bank_d = BANK_RST;
      sync_d = '0;
      txp_d = '0;
      rxp_d = '0;
    end
    rd_active_d = (st_d == ST_REG_RD) || (st_d == ST_SYNC_RD)
      || (st_d == ST_FIFO_RD) || (st_d == ST_ID_RD);
  end

  // Next byte to send, in tx_word_q three cycles after the event that picked it
  always_comb begin
    tx_word_d = tx_word_q;
    if (fetch2_q) begin
      unique case (st_q)
        ST_REG_RD: tx_word_d = reg_rdata;
        ST_SYNC_RD: tx_word_d = sync_q[idx_q];
        ST_ID_RD: tx_word_d = CHIP_ID[8*(SYNC_BYTES-1-32'(idx_q)) +: 8];
        ST_FIFO_RD: tx_word_d = rx_fifo_rdata;
        default: tx_word_d = BYTE_RST;
      endcase
    end
  end

  // RQ17 hold in sleep
  // RQ20 per-mode enables
  always_comb begin
    sleeping = (mode_q == MODE_DEEP) || (mode_q == MODE_LIGHT);
    gio_d = sleeping ? gio_q : {gio_two_drive, gio_two_level, gio_one_drive, gio_one_level};
    en_d[0] = mode_d == MODE_IDLE;
    en_d[1] = (mode_d == MODE_LIGHT) || (mode_d == MODE_STANDBY) || (mode_d == MODE_TX)
      || (mode_d == MODE_RX);
    en_d[2] = en_d[1];
    en_d[3] = (mode_d == MODE_STANDBY) || (mode_d == MODE_TX) || (mode_d == MODE_RX);
    en_d[4] = mode_d == MODE_TX;
    en_d[5] = mode_d == MODE_RX;
  end

  // RQ18 seven modes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= ST_CMD;
      mode_q <= MODE_PWR_DOWN;
      addr_q <= '0;
      bank_q <= BANK_RST;
      idx_q <= '0;
      txp_q <= '0;
      rxp_q <= '0;
      sync_q <= '0;
      fetch_q <= 1'b0;
      fetch2_q <= 1'b0;
      tx_word_q <= BYTE_RST;
      rd_active_q <= 1'b0;
      tog_seen_q <= 1'b0;
      txw_q <= 1'b0;
      rxr_q <= 1'b0;
      en_q <= '0;
      gio_q <= '0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      bank_q <= bank_d;
      idx_q <= idx_d;
      txp_q <= txp_d;
      rxp_q <= rxp_d;
      sync_q <= sync_d;
      fetch_q <= fetch_d;
      fetch2_q <= fetch_q;
      tx_word_q <= tx_word_d;
      rd_active_q <= rd_active_d;
      tog_seen_q <= tog_sync;
      txw_q <= txw_d;
      rxr_q <= rxr_d;
      en_q <= en_d;
      gio_q <= gio_d;
    end
  end

  // RQ20 registers lost in power down
  rscp_regfile #(.AW(BANK_W + ADDR_W), .DW(8)) u_regs (
    .clk(sys_clk),
    .clear(reset || soft_rst || (mode_q == MODE_PWR_DOWN)),
    .we(reg_we),
    .waddr({bank_q, addr_q}),
    .wdata(rx_word_q),
    .raddr({bank_q, addr_q}),
    .rdata_q(reg_rdata)
  );

  assign tx_fifo_we = txw_q;
  assign rx_fifo_re = rxr_q;
  assign tx_fifo_wdata = rx_word_q;
  assign tx_fifo_ptr = txp_q;
  assign rx_fifo_ptr = rxp_q;
  assign frame_sync_pattern = sync_q;
  assign op_mode = mode_q;
  assign {rx_en, tx_en, synth_en, xtal_en, regulator_en, low_freq_rc_osc_en} = en_q;

  pwr_exit_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ24
    mode_q == MODE_PWR_DOWN |=> mode_q == MODE_DEEP) else $error("power down not left");
  strobe_rx_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ19
    cmd_evt && rx_word_q == CMD_RX |=> mode_q == MODE_RX && rx_en)
    else $error("rx strobe ignored");
  reg_step_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ15
    evt && !rx_cmd_q && st_q == ST_REG_WR |-> reg_we ##1 addr_q == $past(addr_q) + 6'h01)
    else $error("address not stepped");
  addr_wrap_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ3
    evt && !rx_cmd_q && st_q == ST_REG_RD && addr_q == 6'h3F |=> addr_q == 6'h00)
    else $error("address did not wrap");
  bank_sel_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
    cmd_evt && rx_word_q[7:5] == PFX_BANK |=> bank_q == $past(rx_word_q[1:0]))
    else $error("bank not selected");
  id_prio_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ12
    cmd_evt && rx_word_q == CMD_CHIP_ID |=> st_q == ST_ID_RD ##2 tx_word_q == CHIP_ID[31:24])
    else $error("identity not returned");
  unknown_cmd_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ23
    cmd_evt && (rx_word_q & 8'h78) == 8'h00 && mode_q != MODE_PWR_DOWN
    |=> mode_q == $past(mode_q) && st_q == ST_IGNORE && txp_q == $past(txp_q)
      && bank_q == $past(bank_q))
    else $error("unknown command acted");
  ptr_reset_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ13
    cmd_evt && rx_word_q == CMD_TXPTR_RST |=> tx_fifo_ptr == '0) else $error("ptr kept");
  sleep_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ17
    sleeping && $past(sleeping) |-> $stable(gio_q)) else $error("gio moved in sleep");
  mode_en_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ20
    mode_q == MODE_TX |-> tx_en && !rx_en && synth_en && !low_freq_rc_osc_en)
    else $error("tx enables wrong");
  reg_write_c: cover property (@(posedge sys_clk) disable iff (reset)
    reg_we ##[1:600] reg_we);
  reg_read_c: cover property (@(posedge sys_clk) disable iff (reset)
    st_q == ST_REG_RD && fetch2_q);
  fifo_read_c: cover property (@(posedge sys_clk) disable iff (reset) rx_fifo_re);
  tx_mode_c: cover property (@(posedge sys_clk) disable iff (reset) mode_q == MODE_TX);
endmodule : rscp_command_port

// file: rscp_host_model.sv
`timescale 1ns/10ps
module rscp_host_model #(
  parameter real HALF = 125.3
) (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic four_wire_en,
  input wire logic out_on_gio_two,
  input wire logic general_io_one_out,
  input wire logic general_io_two_out
);
  logic drv = 1'b0;
  logic host_oe = 1'b1;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  // Released line shows the inverse so stale data never passes
  assign serial_data_in = serial_data_oe ? serial_data_out : host_oe ? drv : ~serial_data_out;
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
  end
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) begin
      drv = b[k];
      #(HALF);
      serial_clk = 1'b1;
      r[k] = !four_wire_en ? serial_data_in : out_on_gio_two ? general_io_two_out :
        general_io_one_out;
      #(HALF);
      serial_clk = 1'b0;
    end
  endtask : shift
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [7:0] r;
    rx_q.delete();
    chip_select_n = 1'b0;
    #(HALF);
    shift(cmd, r);
    host_oe = !cmd[7];
    for (int i = 0; i < n; i++) begin
      shift((i < tx_q.size()) ? tx_q[i] : 8'h00, r);
      rx_q.push_back(r);
    end
    #(HALF);
    chip_select_n = 1'b1;
    host_oe = 1'b1;
    tx_q.delete();
    #(4 * HALF);
  endtask : xfer
endmodule : rscp_host_model

// file: test_radio_spi_command_port.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_radio_spi_command_port import rscp_pkg::*;;
  // Arbitrary identity value
  localparam logic [31:0] ID_VAL = 32'hC3A5_0F12;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic serial_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_oe;
  logic four_wire_en = 1'b0;
  logic out_on_gio_two = 1'b0;
  logic gio_one_level = 1'b0;
  logic gio_one_drive = 1'b1;
  logic gio_two_level = 1'b1;
  logic gio_two_drive = 1'b1;
  logic general_io_one_out, general_io_one_oe, general_io_two_out, general_io_two_oe;
  logic tx_fifo_we, rx_fifo_re;
  logic [7:0] tx_fifo_wdata, rx_fifo_rdata;
  logic [5:0] tx_fifo_ptr, rx_fifo_ptr;
  logic [31:0] frame_sync_pattern;
  rscp_mode_e op_mode;
  logic low_freq_rc_osc_en, regulator_en, xtal_en, synth_en, tx_en, rx_en;
  logic [7:0] shadow [256];
  logic [7:0] exp_q[$];
  logic [7:0] seen_q[$];
  logic [7:0] st_cmd[6] = '{CMD_LIGHT, CMD_STANDBY, CMD_TX, CMD_RX, CMD_IDLE, CMD_DEEP};
  rscp_mode_e st_mode[6] = '{MODE_LIGHT, MODE_STANDBY, MODE_TX, MODE_RX, MODE_IDLE, MODE_DEEP};
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 78;
  int n_re = 0;
  logic [7:0] junk;
  logic [31:0] synth_w;
  // Plain defaults for the divider check
  localparam longint XTAL_HZ = 16000000;
  localparam longint RF_HZ = 433000000;
  localparam longint OUTPUT_DIVIDER_RATIO = 2;

  function automatic logic [7:0] rx_pat(input logic [5:0] p);
    return {2'h1, p} ^ 8'h5A;
  endfunction : rx_pat
  function automatic logic [5:0] en_of(input rscp_mode_e m);
    case (m)
      MODE_IDLE: return 6'h20;
      MODE_LIGHT: return 6'h18;
      MODE_STANDBY: return 6'h1C;
      MODE_TX: return 6'h1E;
      MODE_RX: return 6'h1D;
      default: return 6'h00;
    endcase
  endfunction : en_of
  function automatic logic [31:0] synth_fields(input longint f_lo, input longint f_ref);
    longint n;
    longint k;
    n = f_lo / f_ref;
    k = ((f_lo % f_ref) << 20) / f_ref;
    return {5'h00, n[6:0], k[19:0]};
  endfunction : synth_fields

  always #2 sys_clk = ~sys_clk;
  assign rx_fifo_rdata = rx_pat(rx_fifo_ptr);

  rscp_command_port #(.SYNC_BYTES(4), .CHIP_ID(ID_VAL), .FIFO_AW(6)) uut (
    .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .four_wire_en(four_wire_en), .out_on_gio_two(out_on_gio_two),
    .gio_one_level(gio_one_level), .gio_one_drive(gio_one_drive),
    .gio_two_level(gio_two_level), .gio_two_drive(gio_two_drive),
    .general_io_one_out(general_io_one_out), .general_io_one_oe(general_io_one_oe),
    .general_io_two_out(general_io_two_out), .general_io_two_oe(general_io_two_oe),
    .tx_fifo_we(tx_fifo_we), .tx_fifo_wdata(tx_fifo_wdata), .tx_fifo_ptr(tx_fifo_ptr),
    .rx_fifo_re(rx_fifo_re), .rx_fifo_ptr(rx_fifo_ptr), .rx_fifo_rdata(rx_fifo_rdata),
    .frame_sync_pattern(frame_sync_pattern), .op_mode(op_mode),
    .low_freq_rc_osc_en(low_freq_rc_osc_en), .regulator_en(regulator_en),
    .xtal_en(xtal_en), .synth_en(synth_en), .tx_en(tx_en), .rx_en(rx_en)
  );

  rscp_host_model host (
    .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .four_wire_en(four_wire_en),
    .out_on_gio_two(out_on_gio_two), .general_io_one_out(general_io_one_out),
    .general_io_two_out(general_io_two_out)
  );

  task automatic conclude();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Sampled mid-cycle, away from the edge that moves them
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    if (tx_fifo_we === 1'b1) seen_q.push_back(tx_fifo_wdata);
    if (rx_fifo_re === 1'b1) n_re++;
    if (cyc == 70000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  // Sync-side work lands well inside twelve cycles of chip select rising
  task automatic frame(input logic [7:0] cmd, input int n);
    host.xfer(cmd, n);
    settle(12);
  endtask : frame
  task automatic read_chk(input logic [7:0] cmd);
    int n;
    n = exp_q.size();
    frame(cmd, n);
    for (int i = 0; i < n; i++) `CHK(host.rx_q[i], exp_q[i])
    exp_q.delete();
  endtask : read_chk
  task automatic wr_regs(input logic [1:0] bank, input logic [5:0] a, input int n);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      v = 8'($random(seed));
      host.tx_q.push_back(v);
      shadow[{bank, 6'(a + i)}] = v;
    end
    frame({OP_REG_WR, a}, n);
  endtask : wr_regs
  task automatic rd_regs(input logic [1:0] bank, input logic [5:0] a, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(shadow[{bank, 6'(a + i)}]);
    read_chk({OP_REG_RD, a});
  endtask : rd_regs
  task automatic chk_mode(input rscp_mode_e m);
    `CHK(op_mode, m)
    `CHK({low_freq_rc_osc_en, regulator_en, xtal_en, synth_en, tx_en, rx_en}, en_of(m))
  endtask : chk_mode

  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    settle(3);
    chk_mode(MODE_DEEP);
    // Clocking with chip select high must do nothing
    host.shift(CMD_IDLE, junk);
    settle(12);
    chk_mode(MODE_DEEP);
    for (int i = 0; i < 6; i++) begin
      frame(st_cmd[i], 0);
      chk_mode(st_mode[i]);
    end
    // Undefined codes, one with a trailing data byte
    host.tx_q.push_back(8'hFF);
    frame(8'h07, 1);
    frame(8'h80, 0);
    chk_mode(MODE_DEEP);
    `CHK(frame_sync_pattern, 32'h0000_0000)
    frame(CMD_STANDBY, 0);
    gio_one_level = 1'b1;
    settle(6);
    `CHK(general_io_one_out, 1'b1)
    frame(CMD_DEEP, 0);
    gio_one_level = 1'b0;
    settle(6);
    `CHK(general_io_one_out, 1'b1)
    frame(CMD_STANDBY, 0);
    `CHK(general_io_one_out, 1'b0)
    `CHK({general_io_one_oe, general_io_two_out, general_io_two_oe}, 3'h7)
    `CHK(serial_data_oe, 1'b0)
    frame({PFX_BANK, 3'h0, 2'h0}, 0);
    wr_regs(2'h0, 6'h3E, 4);
    rd_regs(2'h0, 6'h3E, 4);
    frame({PFX_BANK, 3'h0, 2'h1}, 0);
    wr_regs(2'h1, 6'h3F, 2);
    four_wire_en = 1'b1;
    for (int g = 0; g < 2; g++) begin
      out_on_gio_two = g[0];
      rd_regs(2'h1, 6'h3E, 3);
    end
    four_wire_en = 1'b0;
    frame({PFX_BANK, 3'h0, 2'h0}, 0);
    rd_regs(2'h0, 6'h3F, 1);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(8'($random(seed)));
      host.tx_q.push_back(exp_q[i]);
    end
    frame({1'b0, PFX_STREAM, 4'h0}, 4);
    for (int i = 0; i < 4; i++) `CHK(frame_sync_pattern[8*i +: 8], exp_q[i])
    read_chk({1'b1, PFX_STREAM, 4'h0});
    for (int i = 3; i >= 0; i--) exp_q.push_back(ID_VAL[8*i +: 8]);
    read_chk(CMD_CHIP_ID);
    seen_q.delete();
    for (int i = 0; i < 3; i++) host.tx_q.push_back(8'($random(seed)));
    exp_q = host.tx_q;
    frame({1'b0, PFX_STREAM, 4'h1}, 3);
    `CHK(seen_q.size(), 3)
    for (int i = 0; i < 3; i++) `CHK(seen_q[i], exp_q[i])
    `CHK(tx_fifo_ptr, 6'h03)
    exp_q.delete();
    for (int i = 0; i < 3; i++) exp_q.push_back(rx_pat(6'(i)));
    read_chk({1'b1, PFX_STREAM, 4'h1});
    `CHK(rx_fifo_ptr, 6'h03)
    `CHK(n_re, 3)
    synth_w = synth_fields(RF_HZ * OUTPUT_DIVIDER_RATIO, XTAL_HZ);
    for (int i = 3; i >= 0; i--) host.tx_q.push_back(synth_w[8*i +: 8]);
    frame({OP_REG_WR, 6'h10}, 4);
    for (int i = 3; i >= 0; i--) exp_q.push_back(synth_w[8*i +: 8]);
    read_chk({OP_REG_RD, 6'h10});
    frame(CMD_RXPTR_RST, 0);
    `CHK(rx_fifo_ptr, 6'h00)
    frame(CMD_TXPTR_RST, 0);
    `CHK(tx_fifo_ptr, 6'h00)
    frame(CMD_SOFT_RST, 0);
    `CHK(frame_sync_pattern, 32'h0000_0000)
    exp_q = '{8'h00, 8'h00};
    read_chk({OP_REG_RD, 6'h3E});
    chk_mode(MODE_STANDBY);
    conclude();
  end
endmodule : test_radio_spi_command_port
